// File: hdl/uosp_axil.sv
// axi4-lite slave front end with one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
`include "uosp_cfg.svh"
module uosp_axil (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [`UOSP_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [`UOSP_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // register file side
  output uosp_pkg::uosp_wreq_t wreq,
  input wire logic wr_hit,
  output logic [`UOSP_ADDR_W-1:0] rd_addr,
  input wire logic rd_hit,
  input wire logic [31:0] rd_word
);
  import uosp_pkg::*;
  uosp_axil_st_t st_q;
  uosp_axil_st_t st_d;
  logic do_wr;
  assign awready = !st_q.aw_v && !st_q.bvalid;
  assign wready = !st_q.w_v && !st_q.bvalid;
  assign arready = !st_q.rvalid;
  assign do_wr = st_q.aw_v && st_q.w_v && !st_q.bvalid;
  assign wreq = '{en: do_wr, addr: st_q.aw_addr, data: st_q.wdata,
                  strb: st_q.wstrb};
  assign rd_addr = araddr;
  always_comb begin
    st_d = st_q;
    if (awvalid && awready) begin
      st_d.aw_v = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      st_d.w_v = 1'b1;
      st_d.wdata = wdata;
      st_d.wstrb = wstrb;
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    if (do_wr) begin
      st_d.bvalid = 1'b1;
      st_d.bresp = wr_hit ? `UOSP_RESP_OKAY : `UOSP_RESP_SLVERR;
      st_d.aw_v = 1'b0;
      st_d.w_v = 1'b0;
    end
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    // unmapped reads answer zero with an error response
    if (arvalid && arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = rd_hit ? rd_word : 32'h0000_0000;
      st_d.rresp = rd_hit ? `UOSP_RESP_OKAY : `UOSP_RESP_SLVERR;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign rvalid = st_q.rvalid;
  assign rdata = st_q.rdata;
  assign rresp = st_q.rresp;
endmodule : uosp_axil
`default_nettype wire

// File: hdl/uosp_cfg.svh
// constants for the usb otg status and power control block
`ifndef UOSP_CFG_SVH
`define UOSP_CFG_SVH
`define UOSP_ADDR_W 8
`define UOSP_OFS_LINE_STATUS 8'h00
`define UOSP_OFS_PIN_CONTROL 8'h04
`define UOSP_OFS_POWER_CONTROL 8'h08
`define UOSP_OFS_IRQ_STATUS 8'h0c
`define UOSP_OFS_IRQ_MASK 8'h10
`define UOSP_LB_CABLE 7
`define UOSP_LB_STABLE 5
`define UOSP_LB_SESSV 3
`define UOSP_LB_SESSE 2
`define UOSP_LB_VBUSV 0
`define UOSP_PB_DPPU 7
`define UOSP_PB_DMPU 6
`define UOSP_PB_DPPD 5
`define UOSP_PB_DMPD 4
`define UOSP_PB_PWRON 3
`define UOSP_PB_SWCTL 2
`define UOSP_PB_CHG 1
`define UOSP_PB_DIS 0
`define UOSP_WB_PEND 7
`define UOSP_WB_GUARD 4
`define UOSP_WB_BUSY 3
`define UOSP_WB_SUSP 1
`define UOSP_WB_EN 0
`define UOSP_IB_ACT 4
`define UOSP_IRQ_IMPL 8'hbd
`define UOSP_S_CABLE 0
`define UOSP_S_SE0 1
`define UOSP_S_J 2
`define UOSP_S_SESSV 3
`define UOSP_S_VBUSV 4
`define UOSP_S_ACT 5
`define UOSP_S_W 6
`define UOSP_CLK_KHZ 20000
`define UOSP_STABLE_MS 1
`define UOSP_STABLE_CYCLES (`UOSP_STABLE_MS * `UOSP_CLK_KHZ)
`define UOSP_CNT_W 15
`define UOSP_SHUTDOWN_CYCLES 8'h10
`define UOSP_RESP_OKAY 2'h0
`define UOSP_RESP_SLVERR 2'h2
`endif

// File: hdl/uosp_pkg.sv
// types shared by the usb otg status and power control block
`include "uosp_cfg.svh"
package uosp_pkg;
  typedef struct packed {
    logic en;
    logic [`UOSP_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } uosp_wreq_t;
  typedef enum logic [2:0] {
    UOSP_REG_NONE = 3'b000,
    UOSP_REG_LINE = 3'b001,
    UOSP_REG_PIN = 3'b010,
    UOSP_REG_PWR = 3'b011,
    UOSP_REG_ISTAT = 3'b100,
    UOSP_REG_IMASK = 3'b101
  } uosp_reg_e_t;
  typedef struct packed {
    logic [`UOSP_S_W-1:0] s1;
    logic [`UOSP_S_W-1:0] s2;
    logic [`UOSP_S_W-1:0] s3;
    logic [`UOSP_S_W-1:0] stable;
  } uosp_sync_st_t;
  typedef struct packed {
    logic aw_v;
    logic [`UOSP_ADDR_W-1:0] aw_addr;
    logic w_v;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } uosp_axil_st_t;
  typedef struct packed {
    logic [7:0] pin_ctl;
    logic guard;
    logic suspend;
    logic enable;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [`UOSP_S_W-1:0] prev;
    logic [`UOSP_CNT_W-1:0] stable_cnt;
    logic line_stable;
    logic act_pend;
    logic [7:0] busy_cnt;
  } uosp_top_st_t;
endpackage : uosp_pkg

// File: hdl/uosp_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "uosp_cfg.svh"
module uosp_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw and filtered levels
  input wire logic [`UOSP_S_W-1:0] raw,
  output logic [`UOSP_S_W-1:0] level
);
  import uosp_pkg::*;
  uosp_sync_st_t st_q;
  uosp_sync_st_t st_d;
  logic [`UOSP_S_W-1:0] agree;
  // s1 is read by s2 only; a bit moves once s2 and s3 agree
  always_comb begin
    st_d = st_q;
    agree = ~(st_q.s2 ^ st_q.s3);
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.stable = (agree & st_q.s3) | (~agree & st_q.stable);
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign level = st_q.stable;
endmodule : uosp_sync
`default_nettype wire

// File: hdl/uosp_top.sv
// usb otg status, resistor, bus power and module power control
`timescale 1ns/1ps
`default_nettype none
`include "uosp_cfg.svh"
module uosp_top #(
  parameter int unsigned LINE_STABLE_CYCLES = `UOSP_STABLE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [`UOSP_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [`UOSP_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // asynchronous pins and comparators
  input wire logic cable_type_pin_state,
  input wire logic se0_line_state,
  input wire logic j_line_state,
  input wire logic session_valid_cmp,
  input wire logic a_bus_power_valid_cmp,
  input wire logic bus_activity,
  // resistor requests from usb hardware
  input wire logic hw_dplus_pullup,
  input wire logic hw_dminus_pullup,
  input wire logic hw_dplus_pulldown,
  input wire logic hw_dminus_pulldown,
  // line resistor and bus power controls
  output logic dplus_pullup_enable,
  output logic dminus_pullup_enable,
  output logic dplus_pulldown_enable,
  output logic dminus_pulldown_enable,
  output logic bus_power_on,
  output logic bus_power_charge_enable,
  output logic bus_power_discharge_enable,
  // clocking, power and sleep
  output logic usb_clk_enable,
  output logic xcvr_low_power,
  output logic pins_owned_by_usb,
  output logic module_busy,
  output logic sleep_block,
  // interrupt
  output logic irq
);
  import uosp_pkg::*;

  localparam logic [`UOSP_CNT_W-1:0] STABLE_LIM =
    `UOSP_CNT_W'(LINE_STABLE_CYCLES);

  uosp_top_st_t st_q;
  uosp_top_st_t st_d;
  uosp_wreq_t wreq;
  logic wr_hit;
  logic rd_hit;
  logic [`UOSP_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_word;
  logic [`UOSP_S_W-1:0] sync;
  logic [7:0] line_word;
  logic [7:0] pwr_word;
  logic prot_unused;

  // protection bits carry no meaning for this block
  assign prot_unused = ^{awprot, arprot};

  function automatic uosp_reg_e_t reg_decode(
    input logic [`UOSP_ADDR_W-1:0] a
  );
    case (a)
      `UOSP_OFS_LINE_STATUS: reg_decode = UOSP_REG_LINE;
      `UOSP_OFS_PIN_CONTROL: reg_decode = UOSP_REG_PIN;
      `UOSP_OFS_POWER_CONTROL: reg_decode = UOSP_REG_PWR;
      `UOSP_OFS_IRQ_STATUS: reg_decode = UOSP_REG_ISTAT;
      `UOSP_OFS_IRQ_MASK: reg_decode = UOSP_REG_IMASK;
      default: reg_decode = UOSP_REG_NONE;
    endcase
  endfunction : reg_decode

  // cable level enters inverted so the synchroniser's reset value
  // matches an idle pin; no false cable change after reset
  uosp_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .raw({bus_activity, a_bus_power_valid_cmp, session_valid_cmp,
          j_line_state, se0_line_state, ~cable_type_pin_state}),
    .level(sync)
  );

  uosp_axil u_axil (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wreq(wreq),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_hit(rd_hit),
    .rd_word(rd_word)
  );

  // status word; unused positions stay zero
  always_comb begin
    line_word = 8'h00;
    line_word[`UOSP_LB_CABLE] = ~sync[`UOSP_S_CABLE];
    line_word[`UOSP_LB_STABLE] = st_q.line_stable;
    line_word[`UOSP_LB_SESSV] = sync[`UOSP_S_SESSV];
    line_word[`UOSP_LB_SESSE] = ~sync[`UOSP_S_SESSV];
    line_word[`UOSP_LB_VBUSV] = sync[`UOSP_S_VBUSV];
    pwr_word = 8'h00;
    pwr_word[`UOSP_WB_PEND] = st_q.act_pend;
    pwr_word[`UOSP_WB_GUARD] = st_q.guard;
    pwr_word[`UOSP_WB_BUSY] = module_busy;
    pwr_word[`UOSP_WB_SUSP] = st_q.suspend;
    pwr_word[`UOSP_WB_EN] = st_q.enable;
  end

  assign wr_hit = reg_decode(wreq.addr) != UOSP_REG_NONE;
  assign rd_hit = reg_decode(rd_addr) != UOSP_REG_NONE;

  // upper 24 bits always read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_decode(rd_addr))
      UOSP_REG_LINE: rd_word[7:0] = line_word;
      UOSP_REG_PIN: rd_word[7:0] = st_q.pin_ctl;
      UOSP_REG_PWR: rd_word[7:0] = pwr_word;
      UOSP_REG_ISTAT: rd_word[7:0] = st_q.irq_stat;
      UOSP_REG_IMASK: rd_word[7:0] = st_q.irq_mask;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  logic wr_en;
  uosp_reg_e_t wr_sel;
  logic [`UOSP_S_W-1:0] chg;
  logic [7:0] ev;
  logic line_chg;
  assign wr_en = wreq.en && wreq.strb[0];
  assign wr_sel = reg_decode(wreq.addr);
  assign chg = sync ^ st_q.prev;
  assign line_chg = chg[`UOSP_S_SE0] | chg[`UOSP_S_J];

  always_comb begin
    st_d = st_q;
    st_d.prev = sync;
    ev = 8'h00;
    // a line change restarts the stability window
    if (line_chg) begin
      st_d.stable_cnt = '0;
      st_d.line_stable = 1'b0;
    end else if (!st_q.line_stable) begin
      if (st_q.stable_cnt >= STABLE_LIM - `UOSP_CNT_W'(1)) begin
        st_d.line_stable = 1'b1;
        ev[`UOSP_LB_STABLE] = 1'b1;
      end else begin
        st_d.stable_cnt = st_q.stable_cnt + `UOSP_CNT_W'(1);
      end
    end
    ev[`UOSP_LB_CABLE] = chg[`UOSP_S_CABLE];
    ev[`UOSP_IB_ACT] = chg[`UOSP_S_ACT] & sync[`UOSP_S_ACT];
    ev[`UOSP_LB_SESSV] = chg[`UOSP_S_SESSV];
    ev[`UOSP_LB_SESSE] = chg[`UOSP_S_SESSV];
    ev[`UOSP_LB_VBUSV] = chg[`UOSP_S_VBUSV];
    if (wr_en) begin
      unique case (wr_sel)
        UOSP_REG_PIN: st_d.pin_ctl = wreq.data[7:0];
        UOSP_REG_PWR: begin
          st_d.guard = wreq.data[`UOSP_WB_GUARD];
          st_d.suspend = wreq.data[`UOSP_WB_SUSP];
          st_d.enable = wreq.data[`UOSP_WB_EN];
        end
        UOSP_REG_ISTAT: begin
          st_d.irq_stat = st_q.irq_stat & ~(wreq.data[7:0]);
        end
        UOSP_REG_IMASK: begin
          st_d.irq_mask = wreq.data[7:0] & `UOSP_IRQ_IMPL;
        end
        UOSP_REG_LINE: st_d.pin_ctl = st_q.pin_ctl;
        UOSP_REG_NONE: st_d.pin_ctl = st_q.pin_ctl;
      endcase
    end
    // a new event wins over a clear in the same cycle
    st_d.irq_stat = (st_d.irq_stat | ev) & `UOSP_IRQ_IMPL;
    // pending lasts until the unmasked activity interrupt fires
    if (st_q.irq_stat[`UOSP_IB_ACT] && st_q.irq_mask[`UOSP_IB_ACT]) begin
      st_d.act_pend = 1'b0;
    end
    if (ev[`UOSP_IB_ACT]) begin
      st_d.act_pend = 1'b1;
    end
    // shutdown keeps busy up for 16 cycles after disable; re-enable is not blocked
    if (st_q.enable) begin
      st_d.busy_cnt = `UOSP_SHUTDOWN_CYCLES;
    end else if (st_q.busy_cnt != 8'h00) begin
      st_d.busy_cnt = st_q.busy_cnt - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  logic en;
  logic sw;
  assign en = st_q.enable;
  assign sw = st_q.pin_ctl[`UOSP_PB_SWCTL];
  assign dplus_pullup_enable = en &
    (sw ? st_q.pin_ctl[`UOSP_PB_DPPU] : hw_dplus_pullup);
  assign dminus_pullup_enable = en &
    (sw ? st_q.pin_ctl[`UOSP_PB_DMPU] : hw_dminus_pullup);
  assign dplus_pulldown_enable = en &
    (sw ? st_q.pin_ctl[`UOSP_PB_DPPD] : hw_dplus_pulldown);
  assign dminus_pulldown_enable = en &
    (sw ? st_q.pin_ctl[`UOSP_PB_DMPD] : hw_dminus_pulldown);
  assign bus_power_on = en & st_q.pin_ctl[`UOSP_PB_PWRON];
  assign bus_power_charge_enable = en & st_q.pin_ctl[`UOSP_PB_CHG];
  assign bus_power_discharge_enable =
    en & st_q.pin_ctl[`UOSP_PB_DIS];
  assign usb_clk_enable = en & ~st_q.suspend;
  assign xcvr_low_power = ~en | st_q.suspend;
  assign pins_owned_by_usb = en;
  assign module_busy = en | (st_q.busy_cnt != 8'h00);
  assign sleep_block = st_q.guard &
    (sync[`UOSP_S_ACT] | st_q.act_pend);
  assign irq = |(st_q.irq_stat & st_q.irq_mask);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_disable;
    $fell(st_q.enable);
  endsequence
  sequence s_line_move;
    $changed(sync[`UOSP_S_SE0]) || $changed(sync[`UOSP_S_J]);
  endsequence

  chk_cable_flag: assert property (
    $changed(sync[`UOSP_S_CABLE]) |-> ##1 st_q.irq_stat[`UOSP_LB_CABLE])
    else $error("cable change did not raise its flag");
  chk_line_restart: assert property (
    s_line_move |-> ##1 !st_q.line_stable)
    else $error("line stable survived a line change");
  chk_line_hold: assert property (
    $rose(st_q.line_stable) |->
      $past(st_q.stable_cnt) == STABLE_LIM - `UOSP_CNT_W'(1))
    else $error("line stable rose at the wrong count");
  chk_sess_pair: assert property (
    line_word[`UOSP_LB_SESSE] != line_word[`UOSP_LB_SESSV])
    else $error("session end not inverse of session valid");
  chk_sw_resistor: assert property (
    en && !sw |-> dplus_pullup_enable == hw_dplus_pullup &&
      dminus_pulldown_enable == hw_dminus_pulldown)
    else $error("hardware resistor request not followed");
  chk_off_quiet: assert property (
    !en |-> !(dplus_pullup_enable || dminus_pullup_enable ||
      dplus_pulldown_enable || dminus_pulldown_enable ||
      bus_power_on || bus_power_charge_enable ||
      bus_power_discharge_enable || usb_clk_enable))
    else $error("output active while module is off");
  chk_busy_tail: assert property (
    s_disable |-> module_busy [*8])
    else $error("busy dropped too soon after disable");
  chk_pend_set: assert property (
    $rose(sync[`UOSP_S_ACT]) |-> ##1 st_q.act_pend)
    else $error("activity did not set pending");
  chk_sleep_free: assert property (
    !st_q.guard |-> !sleep_block)
    else $error("sleep blocked with guard clear");
  chk_suspend_gate: assert property (
    st_q.suspend |-> !usb_clk_enable && xcvr_low_power)
    else $error("usb clock running in suspend");
  chk_upper_zero: assert property (
    rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
endmodule : uosp_top
`default_nettype wire

// File: verification/uosp_cable_model.sv
// cable, transceiver and remote end model driving pin levels
`timescale 1ns/1ps
`default_nettype none
module uosp_cable_model (
  // clock
  input wire logic sys_clk,
  // pin and comparator levels
  output logic cable_type_pin_state,
  output logic se0_line_state,
  output logic j_line_state,
  output logic session_valid_cmp,
  output logic a_bus_power_valid_cmp,
  output logic bus_activity,
  // resistor requests of the usb hardware
  output logic [3:0] hw_res
);
  initial begin
    cable_type_pin_state = 1'h1;
    se0_line_state = 1'h0;
    j_line_state = 1'h0;
    session_valid_cmp = 1'h0;
    a_bus_power_valid_cmp = 1'h0;
    bus_activity = 1'h0;
    hw_res = 4'ha;
  end
  // levels move just after an edge and then stay put
  task automatic set_pins(input logic c, s, j, v, a);
    @(posedge sys_clk);
    cable_type_pin_state <= c;
    se0_line_state <= s;
    j_line_state <= j;
    session_valid_cmp <= v;
    a_bus_power_valid_cmp <= a;
  endtask : set_pins
  // held long enough for the agreement filter to keep it
  task automatic act_pulse();
    @(posedge sys_clk);
    bus_activity <= 1'h1;
    repeat (6) @(posedge sys_clk);
    bus_activity <= 1'h0;
  endtask : act_pulse
  task automatic set_hw(input logic [3:0] h);
    @(posedge sys_clk);
    hw_res <= h;
  endtask : set_hw
endmodule : uosp_cable_model
`default_nettype wire

// File: verification/uosp_top_tb.sv
// self-checking bench for the otg status and power control block
`timescale 1ns/1ps
`default_nettype none
`include "uosp_cfg.svh"
module uosp_top_tb;
  import uosp_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] prot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic cable_type_pin_state, se0_line_state, j_line_state;
  logic session_valid_cmp, a_bus_power_valid_cmp, bus_activity;
  logic [3:0] hw_res;
  logic dplus_pullup_enable, dminus_pullup_enable;
  logic dplus_pulldown_enable, dminus_pulldown_enable;
  logic bus_power_on, bus_power_charge_enable, bus_power_discharge_enable;
  logic usb_clk_enable, xcvr_low_power, pins_owned_by_usb;
  logic module_busy, sleep_block;
  logic [9:0] outv;
  int mismatches = 0;
  int compares = 0;
  assign outv = {dplus_pullup_enable, dminus_pullup_enable,
    dplus_pulldown_enable, dminus_pulldown_enable, bus_power_on,
    bus_power_charge_enable, bus_power_discharge_enable, usb_clk_enable,
    xcvr_low_power, pins_owned_by_usb};
  // short count keeps the run small; expectations use the same 20
  uosp_top #(.LINE_STABLE_CYCLES(20)) u_uosp_top (
    .sys_clk, .rst_n, .awvalid, .awready, .awaddr, .awprot(prot),
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(prot), .rvalid, .rready,
    .rdata, .rresp, .cable_type_pin_state, .se0_line_state,
    .j_line_state, .session_valid_cmp, .a_bus_power_valid_cmp,
    .bus_activity, .hw_dplus_pullup(hw_res[3]),
    .hw_dminus_pullup(hw_res[2]), .hw_dplus_pulldown(hw_res[1]),
    .hw_dminus_pulldown(hw_res[0]), .dplus_pullup_enable,
    .dminus_pullup_enable, .dplus_pulldown_enable,
    .dminus_pulldown_enable, .bus_power_on, .bus_power_charge_enable,
    .bus_power_discharge_enable, .usb_clk_enable, .xcvr_low_power,
    .pins_owned_by_usb, .module_busy, .sleep_block, .irq
  );
  uosp_cable_model u_uosp_cable_model (
    .sys_clk, .cable_type_pin_state, .se0_line_state, .j_line_state,
    .session_valid_cmp, .a_bus_power_valid_cmp, .bus_activity, .hw_res
  );
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // ready is looked at mid-cycle, where it is settled for the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    logic ta, tw;
    logic tb = 1'h0;
    logic [1:0] r = 2'h3;
    int n = 0;
    // one edge apart from the previous call's release
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tb && n < 100) begin
      @(negedge sys_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
      n++;
    end
    cmp({30'h0, r}, {30'h0, er});
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = 2'h0);
    logic ta;
    logic t = 1'h0;
    logic [31:0] d = 32'h0;
    logic [1:0] r = 2'h3;
    int n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!t && n < 100) begin
      @(negedge sys_clk);
      ta = arvalid && arready;
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (ta) arvalid <= 1'h0;
      if (t) rready <= 1'h0;
      n++;
    end
    cmp(d, e);
    cmp({30'h0, r}, {30'h0, er});
  endtask : rdc
  task automatic oc(input logic [9:0] e);
    repeat (2) @(negedge sys_clk);
    cmp({22'h0, outv}, {22'h0, e});
    @(posedge sys_clk);
  endtask : oc
  task automatic sc(input logic [2:0] e);
    repeat (2) @(negedge sys_clk);
    cmp({29'h0, sleep_block, irq, module_busy}, {29'h0, e});
    @(posedge sys_clk);
  endtask : sc
  initial begin
    logic [7:0] v;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (30) @(posedge sys_clk);
    rdc(8'h00, 32'ha4);
    rdc(8'h0c, 32'h20);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h10, 32'h0);
    oc(10'h002);
    wr(8'h04, 32'hffff_ffff);
    rdc(8'h04, 32'hff);
    oc(10'h002);
    wr(8'h08, 32'h1);
    oc(10'h3fd);
    for (int i = 0; i < 8; i++) begin
      v = 8'h04 | (8'h01 << i);
      wr(8'h04, {24'h0, v});
      oc({v[7:4], v[3], v[1], v[0], 3'h5});
    end
    wr(8'h04, 32'h0);
    oc(10'h285);
    u_uosp_cable_model.set_hw(4'h5);
    oc(10'h145);
    wr(8'h08, 32'hffff_ffff);
    rdc(8'h08, 32'h1b);
    oc(10'h143);
    // activity, pending flag and sleep guard
    wr(8'h08, 32'h11);
    wr(8'h0c, 32'hff);
    u_uosp_cable_model.act_pulse();
    sc(3'h5);
    rdc(8'h08, 32'h99);
    wr(8'h10, 32'h10);
    sc(3'h3);
    rdc(8'h08, 32'h19);
    wr(8'h0c, 32'h10);
    sc(3'h1);
    // line state change restarts the stability count
    u_uosp_cable_model.set_pins(1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    repeat (6) @(posedge sys_clk);
    rdc(8'h00, 32'h84);
    repeat (30) @(posedge sys_clk);
    rdc(8'h00, 32'ha4);
    // cable and bus power comparators
    wr(8'h0c, 32'hff);
    u_uosp_cable_model.set_pins(1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
    repeat (8) @(posedge sys_clk);
    rdc(8'h00, 32'h29);
    wr(8'h00, 32'hffff_ffff);
    rdc(8'h00, 32'h29);
    rdc(8'h0c, 32'h8d);
    wr(8'h10, 32'h80);
    sc(3'h3);
    wr(8'h10, 32'h0);
    sc(3'h1);
    wr(8'h0c, 32'h80);
    rdc(8'h0c, 32'h0d);
    wr(8'h10, 32'hffff_ffff);
    rdc(8'h10, 32'hbd);
    sc(3'h3);
    wr(8'h0c, 32'hff);
    sc(3'h1);
    rdc(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    // shutdown: busy outlives the enable bit for a while
    wr(8'h08, 32'h0);
    sc(3'h1);
    repeat (6) @(posedge sys_clk);
    sc(3'h1);
    repeat (12) @(posedge sys_clk);
    sc(3'h0);
    oc(10'h002);
    rdc(8'h08, 32'h0);
    test_done();
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule : uosp_top_tb
`default_nettype wire
